// File: dv/jtag_debug_port_props.sv
`timescale 1ns/1ps
// pin-level watcher of the debug port, bound into the top module
module jtag_debug_port_props #(
    parameter logic [31:0] ID_VALUE = 32'h0123_4567, // arbitrary value
    parameter logic [3:0] REVISION = 4'h0 // arbitrary value
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic TCK_I,
    input wire logic TRST_N_I,
    input wire logic SYSTEM_RESET_N_I,
    input wire logic EMULATOR_MODE_SELECT_I,
    input wire logic STANDBY_I,
    input wire logic IRQ_ACK_I,
    input wire logic TDO_OE_O,
    input wire logic SYS_RESET_O,
    input wire logic PORT_RESET_O,
    input wire logic CPU_HOLD_O,
    input wire logic DBG_IRQ_O,
    input wire logic [3:0] DBG_IRQ_LEVEL_O,
    input wire logic [15:0] ID_UPPER_HALF_O,
    input wire logic [15:0] ID_LOWER_HALF_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // four samples cover the two-flop synchronisers and the hold flop
    sequence s_all_low;
        (!EMULATOR_MODE_SELECT_I && !SYSTEM_RESET_N_I && !TRST_N_I) [*4];
    endsequence
    sequence s_res_low;
        !SYSTEM_RESET_N_I [*4];
    endsequence
    chk_id_upper: assert property (
        !$past(RST_I) |-> ID_UPPER_HALF_O == {REVISION, ID_VALUE[27:16]})
        else $error("id upper half wrong");
    chk_id_lower: assert property (
        !$past(RST_I) |-> ID_LOWER_HALF_O == ID_VALUE[15:0])
        else $error("id lower half wrong");
    chk_irq_level: assert property (DBG_IRQ_O |-> DBG_IRQ_LEVEL_O == 4'hF)
        else $error("irq level not fifteen");
    chk_ack_clears: assert property (IRQ_ACK_I |=> !DBG_IRQ_O)
        else $error("irq survived ack");
    chk_standby_mask: assert property (STANDBY_I |-> !DBG_IRQ_O)
        else $error("irq seen in standby");
    chk_trst_float: assert property (!TRST_N_I |-> !TDO_OE_O)
        else $error("tdo driven under trst");
    chk_oe_on_rise: assert property ($rose(TDO_OE_O) |-> TCK_I && TRST_N_I)
        else $error("tdo enable away from tck rise");
    chk_port_reset: assert property ($fell(TRST_N_I) |-> ##[1:3] PORT_RESET_O)
        else $error("port reset late");
    chk_sys_reset: assert property (s_res_low |-> SYS_RESET_O)
        else $error("system reset not applied");
    chk_hold_set: assert property (s_all_low |=> CPU_HOLD_O)
        else $error("reset hold not entered");
endmodule // jtag_debug_port_props

bind jtag_debug_port jtag_debug_port_props #(.ID_VALUE(ID_VALUE), .REVISION(REVISION)) u_props (
    .CLK_I(CLK_I), .RST_I(RST_I), .TCK_I(TCK_I), .TRST_N_I(TRST_N_I),
    .SYSTEM_RESET_N_I(SYSTEM_RESET_N_I), .EMULATOR_MODE_SELECT_I(EMULATOR_MODE_SELECT_I),
    .STANDBY_I(STANDBY_I), .IRQ_ACK_I(IRQ_ACK_I), .TDO_OE_O(TDO_OE_O),
    .SYS_RESET_O(SYS_RESET_O), .PORT_RESET_O(PORT_RESET_O), .CPU_HOLD_O(CPU_HOLD_O),
    .DBG_IRQ_O(DBG_IRQ_O), .DBG_IRQ_LEVEL_O(DBG_IRQ_LEVEL_O),
    .ID_UPPER_HALF_O(ID_UPPER_HALF_O), .ID_LOWER_HALF_O(ID_LOWER_HALF_O));

// File: dv/jtag_tester_model.sv
`timescale 1ns/1ps
// external tester: tck parks high between scans, 800 ns period inside
module jtag_tester_model (
    input wire logic clk_i,
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_n_o
);
    initial begin
        tck_o = 1'b1; // parked high so standby entry leaves the tap alone
        tms_o = 1'b1;
        tdi_o = 1'b0;
        trst_n_o = 1'b1;
    end
    // one tck period; tdo read just before the rise, when both timings settled
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tck_o = 1'b0;
        tms_o = tms;
        tdi_o = tdi;
        repeat (4) @(negedge clk_i);
        tdo = tdo_oe_i ? tdo_i : ~tdo_i; // a released line never shows the old bit
        tck_o = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask
    // from idle into a shift state, n bits lsb first, back to idle
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b0, b);
        if (ir) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
    // five ones reach test-logic-reset, then idle
    task automatic tap_reset();
        logic b;
        for (int i = 0; i < 5; i++) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
    task automatic set_trst(input logic v);
        trst_n_o = v;
    endtask
endmodule // jtag_tester_model

// File: dv/tb_jtag_debug_port.sv
`timescale 1ns/1ps
module tb_jtag_debug_port;
    import dbg_port_pkg::*;
    localparam logic [31:0] ID_V = 32'h1357_9BDF; // arbitrary value
    localparam logic [3:0] REV = 4'hA; // arbitrary value
    localparam logic [31:0] ID_EXP = {REV, ID_V[27:0]};
    localparam int POR_CYCLES = 100; // power-on low time stand-in
    logic clk, rst, tck, tms, tdi, trst_n, tdo, tdo_oe, res_n, emu, stby, slp, ack;
    logic sys_rst, port_rst, hold, irq;
    logic [3:0] irq_lvl;
    logic [15:0] id_hi, id_lo;
    logic [7:0] core_out, core_oe, pin_in, pin_out, pin_oe, core_in;
    logic [31:0] d;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;

    jtag_debug_port #(.N_CELLS(8), .ID_VALUE(ID_V), .REVISION(REV)) dut (
        .CLK_I(clk), .RST_I(rst), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
        .TRST_N_I(trst_n), .TDO_O(tdo), .TDO_OE_O(tdo_oe), .SYSTEM_RESET_N_I(res_n),
        .EMULATOR_MODE_SELECT_I(emu), .STANDBY_I(stby), .SLEEP_I(slp), .IRQ_ACK_I(ack),
        .SYS_RESET_O(sys_rst), .PORT_RESET_O(port_rst), .CPU_HOLD_O(hold),
        .DBG_IRQ_O(irq), .DBG_IRQ_LEVEL_O(irq_lvl), .ID_UPPER_HALF_O(id_hi),
        .ID_LOWER_HALF_O(id_lo), .CORE_OUT_I(core_out), .CORE_OE_I(core_oe),
        .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out), .PIN_OE_O(pin_oe), .CORE_IN_O(core_in));

    jtag_tester_model tester (
        .clk_i(clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms),
        .tdi_o(tdi), .trst_n_o(trst_n));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // instruction load; the capture pattern proves tdo drives in shift-ir
    task automatic ld(input logic [7:0] op);
        logic [31:0] c;
        tester.scan(1'b1, {24'h0, op}, 8, c);
        check("ir capture", c, {24'h0, IR_CAPTURE_VAL});
    endtask

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    initial begin
        rst = 1'b1;
        res_n = 1'b1;
        emu = 1'b1;
        stby = 1'b0;
        slp = 1'b0;
        ack = 1'b0;
        core_out = 8'h3C;
        core_oe = 8'hF0;
        pin_in = 8'h5A;
        wt(16);
        rst = 1'b0;
        wt(4);
        check("id upper", id_hi, ID_EXP[31:16]);
        check("id lower", id_lo, ID_EXP[15:0]);
        check("irq level", irq_lvl, 4'hF);
        tester.tap_reset();
        tester.scan(1'b0, 32'h0, 32, d);
        check("idcode shift", d, ID_EXP);
        ld(8'hF0);
        tester.scan(1'b0, 32'hA5, 8, d);
        check("bypass path", d, 32'h4A);
        check("bypass pins", {pin_oe, pin_out}, {core_oe, core_out});
        core_oe = 8'h0F;
        ld(8'h40);
        tester.scan(1'b0, 32'h96, 8, d);
        check("sample capture", d, 32'h3C);
        check("sample pins", {pin_oe, pin_out}, {core_oe, core_out});
        res_n = 1'b0; // system held in reset for pin
        ld(8'h00);
        check("extest drive", {pin_oe, pin_out}, 16'hFF96);
        pin_in = 8'hA5;
        tester.scan(1'b0, 32'hC3, 8, d);
        check("extest capture", d, 32'hA5);
        check("pin input", core_in, pin_in);
        ld(8'h80);
        check("clamp drive", {pin_oe, pin_out}, 16'hFFC3);
        tester.scan(1'b0, 32'h1, 4, d);
        check("clamp bypass", d, 32'h2);
        ld(8'h90);
        check("highz float", pin_oe, 8'h00);
        ld(8'hF0);
        res_n = 1'b1;
        wt(4);
        tester.set_trst(1'b0);
        wt(4);
        check("trst float", tdo_oe, 1'b0);
        check("trst port reset", port_rst, 1'b1);
        tester.set_trst(1'b1);
        wt(4);
        tester.step(1'b0, 1'b0, d[0]);
        tester.scan(1'b0, 32'h0, 32, d);
        check("idcode after trst", d, ID_EXP);
        ld(8'h30);
        wt(3);
        check("debug reset on", sys_rst, 1'b1);
        ld(8'hF0);
        wt(POR_CYCLES);
        check("debug reset kept", sys_rst, 1'b1);
        ld(8'h20);
        wt(3);
        check("debug reset off", sys_rst, 1'b0);
        ld(8'hA0);
        wt(3);
        check("irq raised", irq, 1'b1);
        slp = 1'b1;
        wt(2);
        check("irq in sleep", irq, 1'b1);
        stby = 1'b1;
        wt(1);
        check("irq in standby", irq, 1'b0);
        stby = 1'b0;
        slp = 1'b0;
        ack = 1'b1;
        wt(1);
        ack = 1'b0;
        wt(2);
        check("irq cleared", irq, 1'b0);
        ld(8'hA0);
        wt(3);
        check("same command", irq, 1'b0);
        ld(8'hF0);
        stby = 1'b1;
        ld(8'hA0);
        stby = 1'b0;
        wt(3);
        check("standby load", irq, 1'b0);
        ld(8'hA0);
        wt(3);
        check("reissued irq", irq, 1'b1);
        ack = 1'b1;
        wt(1);
        ack = 1'b0;
        for (int i = 0; i < 4; i++) begin
            res_n = i[1];
            tester.set_trst(i[0]);
            wt(5);
            check("sys reset", sys_rst, !i[1]);
            check("port reset", port_rst, !i[0]);
            check("no hold", hold, 1'b0);
        end
        emu = 1'b0;
        res_n = 1'b0;
        tester.set_trst(1'b0);
        wt(5);
        check("hold entered", hold, 1'b1);
        res_n = 1'b1;
        wt(5);
        check("cpu kept", {hold, sys_rst}, 2'b10);
        tester.set_trst(1'b1);
        wt(5);
        check("hold after trst", hold, 1'b1);
        tester.set_trst(1'b0);
        wt(5);
        check("hold cancelled", hold, 1'b0);
        report_and_stop();
    end
endmodule // tb_jtag_debug_port

// File: hw/boundary_chain.sv
`timescale 1ns/1ps
// one capture/shift stage and one parallel output latch per pin
module boundary_chain
    import dbg_port_pkg::*;
#(
    parameter int N_CELLS = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    tap_link_if.chain lnk,
    input wire logic [N_CELLS-1:0] core_out_i, // value the core wants on the pin
    input wire logic [N_CELLS-1:0] core_oe_i, // core drive enable
    input wire logic [N_CELLS-1:0] pin_in_i, // synced pin level
    output logic [N_CELLS-1:0] pin_out_o,
    output logic [N_CELLS-1:0] pin_oe_o
);
    logic [N_CELLS-1:0] shift_r; // serial stages
    logic [N_CELLS-1:0] latch_r; // parallel output latches

    if (N_CELLS < 1) begin : g_bad_cells
        $error("boundary_chain needs at least one cell");
    end

    // capture on rise in capture-dr, shift on the following falls
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_r <= '0;
        end else if (lnk.bsr_sel && lnk.tck_rise && lnk.state == CAP_DR) begin
            // extest watches the board, sample watches the core outputs
            shift_r <= (lnk.bs_mode == BS_EXTEST) ? pin_in_i : core_out_i;
        end else if (lnk.bsr_sel && lnk.tck_fall && lnk.prev == SHF_DR) begin
            // captured output values are pushed out here, never driven
            shift_r <= {lnk.tdi_cap, shift_r[N_CELLS-1:1]};
        end
    end

    // preload or update the latches at update-dr
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_r <= '0;
        end else if (lnk.bsr_sel && lnk.tck_rise && lnk.state == UPD_DR) begin
            latch_r <= shift_r;
        end
    end

    // per-pin override; system pins and tap pins are not in this chain
    genvar g;
    generate
        for (g = 0; g < N_CELLS; g++) begin : g_cell
            always_comb begin
                case (lnk.bs_mode)
                    BS_EXTEST, BS_CLAMP: begin
                        pin_out_o[g] = latch_r[g];
                        pin_oe_o[g] = 1'b1;
                    end
                    BS_HIGHZ: begin
                        pin_out_o[g] = 1'b0;
                        pin_oe_o[g] = 1'b0;
                    end
                    default: begin
                        pin_out_o[g] = core_out_i[g];
                        pin_oe_o[g] = core_oe_i[g];
                    end
                endcase
            end
        end
    endgenerate

    assign lnk.bsr_lsb = shift_r[0];
endmodule // boundary_chain

// File: hw/dbg_port_pkg.sv
package dbg_port_pkg;
    // instruction and identification register geometry
    localparam int IR_W = 8;
    localparam int ID_W = 32;
    localparam int HALF_W = 16;
    // instruction upper nibbles, decoded on bits 7..4
    localparam logic [3:0] OP_EXTEST = 4'h0;
    localparam logic [3:0] OP_SAMPLE = 4'h4;
    localparam logic [3:0] OP_BYPASS = 4'hF;
    localparam logic [3:0] OP_IDCODE = 4'h5;
    localparam logic [3:0] OP_CLAMP = 4'h8;
    localparam logic [3:0] OP_HIGHZ = 4'h9;
    localparam logic [3:0] OP_RST_NEGATE = 4'h2;
    localparam logic [3:0] OP_RST_ASSERT = 4'h3;
    localparam logic [3:0] OP_INTERRUPT = 4'hA;
    // full instruction loaded on port reset
    localparam logic [7:0] IR_RESET_VAL = 8'h50;
    // pattern captured into the instruction shifter
    localparam logic [7:0] IR_CAPTURE_VAL = 8'h01;
    // fixed request level of the debug interrupt
    localparam logic [3:0] DBG_IRQ_LEVEL = 4'hF;
    // top identification bits that follow the silicon revision
    localparam int REV_LSB = 28;
    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;

    // port controller states, binary codes written out
    typedef enum logic [3:0] {
        TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
        SHF_DR = 4'h4, EX1_DR = 4'h5, PAU_DR = 4'h6, EX2_DR = 4'h7,
        UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SHF_IR = 4'hB,
        EX1_IR = 4'hC, PAU_IR = 4'hD, EX2_IR = 4'hE, UPD_IR = 4'hF
    } tap_state_t;

    // what the boundary cells do to the pins
    typedef enum logic [1:0] {
        BS_NORMAL = 2'h0, BS_EXTEST = 2'h1, BS_CLAMP = 2'h2, BS_HIGHZ = 2'h3
    } bs_mode_t;
endpackage

// File: hw/jtag_debug_port.sv
`timescale 1ns/1ps
// Overview of operation
// - 32-bit read-only id, two readable halves
// - idcode in shift-dr shifts id onto tdo
// - upper half bits 31-16, revision nibble
// - standard state diagram, tms at tck rise
// - sample tdi on rise, shift on fall
// - tdo driven only in shift states
// - trst low forces test-logic-reset immediately
// - normal mode reset combinations of pins
// - emulator mode reset-hold keeps cpu halted
// - vendor commands change tdo on rise
// - reset-assert holds power-on reset until negate
// - interrupt command requests priority fifteen exception
// - interrupt accepted in sleep, not standby
// - bypass selects one-bit register, no effect
// - sample/preload captures core outputs, preloads latches
// - extest drives latches, captures input pins
// - idcode on reset; clamp and highz supported
// - chain excludes clock, reset, tap pins
// - command persists; reissue needs another first
module jtag_debug_port
    import dbg_port_pkg::*;
#(
    parameter int N_CELLS = 8,
    parameter logic [31:0] ID_VALUE = 32'h0123_4567, // arbitrary value
    parameter logic [3:0] REVISION = 4'h0 // arbitrary value
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic TCK_I,
    input wire logic TMS_I,
    input wire logic TDI_I,
    input wire logic TRST_N_I,
    output logic TDO_O,
    output logic TDO_OE_O,
    input wire logic SYSTEM_RESET_N_I,
    input wire logic EMULATOR_MODE_SELECT_I,
    input wire logic STANDBY_I,
    input wire logic SLEEP_I,
    input wire logic IRQ_ACK_I,
    output logic SYS_RESET_O,
    output logic PORT_RESET_O,
    output logic CPU_HOLD_O,
    output logic DBG_IRQ_O,
    output logic [3:0] DBG_IRQ_LEVEL_O,
    output logic [15:0] ID_UPPER_HALF_O,
    output logic [15:0] ID_LOWER_HALF_O,
    input wire logic [N_CELLS-1:0] CORE_OUT_I,
    input wire logic [N_CELLS-1:0] CORE_OE_I,
    input wire logic [N_CELLS-1:0] PIN_IN_I,
    output logic [N_CELLS-1:0] PIN_OUT_O,
    output logic [N_CELLS-1:0] PIN_OE_O,
    output logic [N_CELLS-1:0] CORE_IN_O
);
    tap_link_if lnk();

    // pin synchronisers: first stage feeds only the second
    logic [SYNC_STAGES-1:0] tck_s, tms_s, tdi_s, trst_s, res_s, emu_s;
    logic [N_CELLS-1:0] pin_s1, pin_s2;
    logic tck_d; // delayed synced tck for edge finding
    logic tap_rst; // asynchronous reset of the port logic
    logic [IR_W-1:0] ir_r, ir_sr; // loaded command and its shifter
    logic [ID_W-1:0] id_sr; // identification shifter
    logic byp_r; // one-bit bypass stage
    logic tdo_r, dbg_rst_r, irq_r, hold_r, res_d, trst_d;
    logic [ID_W-1:0] id_word; // identification value with revision
    logic [3:0] op; // decoded upper nibble
    logic vendor_cmd, sel_id, dr_lsb, cmd_take;
    logic rise_d, fall_d; // tck pulses one clock late, shift settled

    if (N_CELLS < 1) begin : g_bad_cells
        $error("jtag_debug_port needs boundary cells");
    end

    // the revision nibble may differ, the rest is fixed
    assign id_word = {REVISION, ID_VALUE[REV_LSB-1:0]};

    // trst acts without any clock edge
    assign tap_rst = RST_I | ~TRST_N_I;

    // two-flop synchronisers for every pin input
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tck_s <= '1;
            tms_s <= '1;
            tdi_s <= '1;
            trst_s <= '0;
            res_s <= '0;
            emu_s <= '1;
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            tck_s <= {tck_s[0], TCK_I};
            tms_s <= {tms_s[0], TMS_I};
            tdi_s <= {tdi_s[0], TDI_I};
            trst_s <= {trst_s[0], TRST_N_I};
            res_s <= {res_s[0], SYSTEM_RESET_N_I};
            emu_s <= {emu_s[0], EMULATOR_MODE_SELECT_I};
            pin_s1 <= PIN_IN_I;
            pin_s2 <= pin_s1;
        end
    end

    // edge finder on the settled tck copy
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            // parked-high level, so release shows no false rise
            tck_d <= 1'b1;
            rise_d <= 1'b0;
            fall_d <= 1'b0;
        end else begin
            tck_d <= tck_s[1];
            rise_d <= lnk.tck_rise;
            fall_d <= lnk.tck_fall;
        end
    end

    assign lnk.tck_rise = tck_s[1] & ~tck_d;
    assign lnk.tck_fall = ~tck_s[1] & tck_d;
    assign lnk.tms = tms_s[1];

    // tdi caught on the rise, used by the shift on the fall
    always_ff @(posedge CLK_I or posedge tap_rst) begin
        if (tap_rst) begin
            lnk.tdi_cap <= 1'b0;
            lnk.prev <= TLR;
        end else if (lnk.tck_rise) begin
            lnk.tdi_cap <= tdi_s[1];
            // a fall shifts only after a rise taken in a shift state
            lnk.prev <= lnk.state;
        end
    end

    tap_fsm u_fsm (
        .clk_i(CLK_I),
        .rst_i(tap_rst),
        .lnk(lnk)
    );

    // command decode; unknown codes behave as bypass
    assign op = ir_r[IR_W-1:IR_W-4];
    assign vendor_cmd = (op == OP_RST_ASSERT) || (op == OP_RST_NEGATE)
                        || (op == OP_INTERRUPT);
    assign sel_id = (op == OP_IDCODE);
    assign lnk.bsr_sel = (op == OP_EXTEST) || (op == OP_SAMPLE);

    // pin mode per command; bypass and vendor leave pins alone
    always_comb begin
        case (op)
            OP_EXTEST: lnk.bs_mode = BS_EXTEST;
            OP_CLAMP: lnk.bs_mode = BS_CLAMP;
            OP_HIGHZ: lnk.bs_mode = BS_HIGHZ;
            default: lnk.bs_mode = BS_NORMAL;
        endcase
    end

    // commands are not accepted while the chip is in standby
    assign cmd_take = lnk.tck_rise && lnk.state == UPD_IR && !STANDBY_I;

    // instruction shifter: capture at rise, shift at fall
    always_ff @(posedge CLK_I or posedge tap_rst) begin
        if (tap_rst) begin
            ir_sr <= IR_CAPTURE_VAL;
        end else if (lnk.tck_rise && lnk.state == CAP_IR) begin
            ir_sr <= IR_CAPTURE_VAL;
        end else if (lnk.tck_fall && lnk.prev == SHF_IR) begin
            ir_sr <= {lnk.tdi_cap, ir_sr[IR_W-1:1]};
        end
    end

    // loaded command stays until another is loaded
    always_ff @(posedge CLK_I or posedge tap_rst) begin
        if (tap_rst) begin
            ir_r <= IR_RESET_VAL;
        end else if (lnk.tck_rise && lnk.state == TLR) begin
            ir_r <= IR_RESET_VAL;
        end else if (cmd_take) begin
            ir_r <= ir_sr;
        end
    end

    // data shifters: id and bypass
    always_ff @(posedge CLK_I or posedge tap_rst) begin
        if (tap_rst) begin
            id_sr <= '0;
            byp_r <= 1'b0;
        end else if (lnk.tck_rise && lnk.state == CAP_DR) begin
            id_sr <= id_word;
            byp_r <= 1'b0;
        end else if (lnk.tck_fall && lnk.prev == SHF_DR) begin
            id_sr <= {lnk.tdi_cap, id_sr[ID_W-1:1]};
            byp_r <= lnk.tdi_cap;
        end
    end

    // register selected between tdi and tdo
    always_comb begin
        if (sel_id) begin
            dr_lsb = id_sr[0];
        end else if (lnk.bsr_sel) begin
            dr_lsb = lnk.bsr_lsb;
        end else begin
            dr_lsb = byp_r;
        end
    end

    // tdo launch: standard commands on fall, vendor ones on rise
    always_ff @(posedge CLK_I or posedge tap_rst) begin
        if (tap_rst) begin
            tdo_r <= 1'b0;
        end else if (vendor_cmd && rise_d) begin
            // half a cycle early: present the bit due at the next fall
            if (lnk.state == SHF_IR) begin
                tdo_r <= (lnk.prev == SHF_IR) ? ir_sr[1] : ir_sr[0];
            end else if (lnk.state == SHF_DR) begin
                // vendor commands always route bypass
                tdo_r <= (lnk.prev == SHF_DR) ? lnk.tdi_cap : byp_r;
            end
        end else if (!vendor_cmd && fall_d) begin
            if (lnk.state == SHF_IR) begin
                tdo_r <= ir_sr[0];
            end else if (lnk.state == SHF_DR) begin
                tdo_r <= dr_lsb;
            end
        end
    end

    assign TDO_O = tdo_r;
    assign TDO_OE_O = (lnk.state == SHF_DR) || (lnk.state == SHF_IR);

    // debug reset: set by assert command, held until negate
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            dbg_rst_r <= 1'b0;
        end else if (cmd_take && ir_sr != ir_r) begin
            // a repeated identical load is not a new command
            if (ir_sr[IR_W-1:IR_W-4] == OP_RST_ASSERT) begin
                dbg_rst_r <= 1'b1;
            end else if (ir_sr[IR_W-1:IR_W-4] == OP_RST_NEGATE) begin
                dbg_rst_r <= 1'b0;
            end
        end
    end

    // debug interrupt: pending until the cpu acknowledges it
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_r <= 1'b0;
        end else if (cmd_take && ir_sr != ir_r
                     && ir_sr[IR_W-1:IR_W-4] == OP_INTERRUPT) begin
            irq_r <= 1'b1;
        end else if (IRQ_ACK_I) begin
            irq_r <= 1'b0;
        end
    end

    // sleep still lets the request through, standby blocks it
    assign DBG_IRQ_O = irq_r & ~STANDBY_I;
    assign DBG_IRQ_LEVEL_O = DBG_IRQ_LEVEL;

    // delayed copies for reset and trst edge detection
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            res_d <= 1'b0;
            trst_d <= 1'b0;
        end else begin
            res_d <= res_s[1];
            trst_d <= trst_s[1];
        end
    end

    // reset hold in emulator mode: entered by both low, left by re-assert
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            hold_r <= 1'b0;
        end else if (!emu_s[1] && !res_s[1] && !trst_s[1]) begin
            hold_r <= 1'b1;
        end else if ((res_d && !res_s[1]) || (trst_d && !trst_s[1])) begin
            hold_r <= 1'b0;
        end
    end

    // reset outputs follow the pin table plus the debug reset
    assign SYS_RESET_O = ~res_s[1] | dbg_rst_r;
    assign PORT_RESET_O = ~trst_s[1];
    assign CPU_HOLD_O = hold_r;

    // cpu view of the identification value, writes have no path
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ID_UPPER_HALF_O <= '0;
            ID_LOWER_HALF_O <= '0;
        end else begin
            ID_UPPER_HALF_O <= id_word[ID_W-1:HALF_W];
            ID_LOWER_HALF_O <= id_word[HALF_W-1:0];
        end
    end

    // boundary cells for the general pins only
    boundary_chain #(.N_CELLS(N_CELLS)) u_chain (
        .clk_i(CLK_I),
        .rst_i(tap_rst),
        .lnk(lnk),
        .core_out_i(CORE_OUT_I),
        .core_oe_i(CORE_OE_I),
        .pin_in_i(pin_s2),
        .pin_out_o(PIN_OUT_O),
        .pin_oe_o(PIN_OE_O)
    );

    // inputs pass to the core in every mode
    assign CORE_IN_O = pin_s2;
endmodule // jtag_debug_port

// File: hw/tap_fsm.sv
`timescale 1ns/1ps
// sixteen-state port controller, stepped by synced tck rising edges
module tap_fsm
    import dbg_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i, // system reset or trst low, asynchronous
    tap_link_if.fsm lnk
);
    tap_state_t state_r;

    // next state from the mode select level
    always_comb begin
        case (state_r)
            TLR: lnk.state_nxt = lnk.tms ? TLR : RTI;
            RTI: lnk.state_nxt = lnk.tms ? SEL_DR : RTI;
            SEL_DR: lnk.state_nxt = lnk.tms ? SEL_IR : CAP_DR;
            CAP_DR: lnk.state_nxt = lnk.tms ? EX1_DR : SHF_DR;
            SHF_DR: lnk.state_nxt = lnk.tms ? EX1_DR : SHF_DR;
            EX1_DR: lnk.state_nxt = lnk.tms ? UPD_DR : PAU_DR;
            PAU_DR: lnk.state_nxt = lnk.tms ? EX2_DR : PAU_DR;
            EX2_DR: lnk.state_nxt = lnk.tms ? UPD_DR : SHF_DR;
            UPD_DR: lnk.state_nxt = lnk.tms ? SEL_DR : RTI;
            SEL_IR: lnk.state_nxt = lnk.tms ? TLR : CAP_IR;
            CAP_IR: lnk.state_nxt = lnk.tms ? EX1_IR : SHF_IR;
            SHF_IR: lnk.state_nxt = lnk.tms ? EX1_IR : SHF_IR;
            EX1_IR: lnk.state_nxt = lnk.tms ? UPD_IR : PAU_IR;
            PAU_IR: lnk.state_nxt = lnk.tms ? EX2_IR : PAU_IR;
            EX2_IR: lnk.state_nxt = lnk.tms ? UPD_IR : SHF_IR;
            UPD_IR: lnk.state_nxt = lnk.tms ? SEL_DR : RTI;
            default: lnk.state_nxt = TLR;
        endcase
    end

    // step only on a tck rise; trst forces reset state at once
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= TLR;
        end else if (lnk.tck_rise) begin
            state_r <= lnk.state_nxt;
        end
    end

    assign lnk.state = state_r;
endmodule // tap_fsm

// File: hw/tap_link_if.sv
`timescale 1ns/1ps
// signals shared by the port controller, the boundary chain and the top
interface tap_link_if;
    import dbg_port_pkg::*;
    logic tck_rise; // one-cycle pulse on synced tck rising edge
    logic tck_fall; // one-cycle pulse on synced tck falling edge
    logic tms; // synced mode select
    logic tdi_cap; // data input caught at the last rising edge
    tap_state_t state; // current controller state
    tap_state_t state_nxt; // state after the next rising edge
    tap_state_t prev; // state left at the last tck rise
    logic bsr_sel; // boundary register sits between tdi and tdo
    bs_mode_t bs_mode; // pin override mode
    logic bsr_lsb; // bit presented to tdo by the chain
    modport top (output tck_rise, tck_fall, tms, tdi_cap, bsr_sel, bs_mode, prev,
                 input state, state_nxt, bsr_lsb);
    modport fsm (input tck_rise, tms, output state, state_nxt);
    modport chain (input tck_rise, tck_fall, tdi_cap, state, prev, bsr_sel, bs_mode,
                   output bsr_lsb);
endinterface
